// File: hw/slave_i2c_port.sv
// slave i2c port with its register set, bus engine and interrupt logic
// assumes SCL and SDA arrive asynchronous, open drain resolved by the bench
// What this block does
// - control bit 7 enables the master i2c interrupt, reset zero
// - control bit 6 enables the transmit done interrupt, together with event mask bit 2, reset zero
// - control bit 5 enables the second byte received interrupt, together with event mask bit 1, reset zero
// - control bit 4 enables the first byte received interrupt, together with event mask bit 0, reset zero
// - bit 2 set by hardware when transmission ends, write zero clears, resets one
// - bit 1 set when second receive byte arrives, write zero clears, reset zero
// - bit 0 set when first receive byte arrives, write zero clears, reset zero
// - first received byte readable in a read only register, undefined at reset
// - reading the shared data location returns the second received byte
// - writing the shared data location loads the transmit byte only
// - port answers the 7-bit address in address bits 7..1, reset 64h
// - address bit 0 enables the slave port, reset zero
`timescale 1ns/1ps
module slave_i2c_port
    import slave_i2c_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // master i2c interrupt source from the master engine
    input wire logic MASTER_IRQ_EVENT,
    // interrupt outputs
    output logic IRQ,
    output logic MASTER_IRQ,
    // i2c pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE
);
    // registers
    logic [7:0] slave_address_reg;
    logic [3:0] irq_enable;       // bits 7..4 of control
    logic [2:0] done_flags;       // bits 2..0 of control
    logic [7:0] first_rx_byte;
    logic [7:0] second_rx_byte;
    logic [7:0] tx_byte;
    logic [2:0] event_mask;
    logic master_flag;
    // synchronisers
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    // engine state
    link_state_type state;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic is_read;
    logic [1:0] byte_index;
    logic ack_drive;
    logic [7:0] hold_count;
    logic sda_drive;
    logic sda_level;
    // events
    logic ev_tx_done;
    logic ev_rx_one;
    logic ev_rx_two;
    logic ctrl_wr;
    logic [7:0] control_read;
    logic port_enable;

    // two flip-flop synchronisers; only the second stage is read
    always_ff @(posedge CLK) begin
        if (SRST) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], SCL_IN};
            sda_sync <= {sda_sync[0], SDA_IN};
        end
    end

    // previous synchronised levels for edge detection
    always_ff @(posedge CLK) begin
        if (SRST) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    wire scl = scl_sync[1];
    wire sda = sda_sync[1];
    wire scl_rise = scl & ~scl_prev;
    wire scl_fall = ~scl & scl_prev;
    wire start_cond = scl & scl_prev & sda_prev & ~sda;
    wire stop_cond = scl & scl_prev & ~sda_prev & sda;
    assign port_enable = slave_address_reg[BIT_SLAVE_PORT_ENABLE];
    assign ctrl_wr = WR && (ADDR == ADDR_CONTROL_STATUS);

    // i2c slave engine: address phase, then two writes or reads of the tx byte
    always_ff @(posedge CLK) begin
        if (SRST || !port_enable) begin
            state <= ST_IDLE;
            bit_count <= 4'h0;
            shift <= 8'h00;
            is_read <= 1'b0;
            byte_index <= 2'h0;
            ack_drive <= 1'b0;
            ev_tx_done <= 1'b0;
            ev_rx_one <= 1'b0;
            ev_rx_two <= 1'b0;
        end else begin
            ev_tx_done <= 1'b0;
            ev_rx_one <= 1'b0;
            ev_rx_two <= 1'b0;
            if (start_cond) begin
                state <= ST_ADDR;
                bit_count <= 4'h0;
                byte_index <= 2'h0;
                ack_drive <= 1'b0;
            end else if (stop_cond) begin
                state <= ST_IDLE;
                ack_drive <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        ack_drive <= 1'b0;
                    end
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda};
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall && bit_count == 4'h8) begin
                            bit_count <= 4'h0;
                            if (state == ST_ADDR) begin
                                if (shift[7:1] == slave_address_reg[7:1]) begin
                                    is_read <= shift[0];
                                    ack_drive <= 1'b1;
                                    state <= ST_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                // byte order: first byte then second, extra bytes ignored
                                if (byte_index == 2'h0) begin
                                    ev_rx_one <= 1'b1;
                                end else if (byte_index == 2'h1) begin
                                    ev_rx_two <= 1'b1;
                                end
                                if (byte_index != 2'h3) begin
                                    byte_index <= byte_index + 2'h1;
                                end
                                ack_drive <= 1'b1;
                                state <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        // release ack on the falling edge, then turn to data
                        if (scl_fall) begin
                            ack_drive <= 1'b0;
                            if (is_read) begin
                                shift <= tx_byte;
                                state <= ST_TX;
                            end else begin
                                state <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            shift <= {shift[6:0], 1'b1};
                            bit_count <= bit_count + 4'h1;
                            if (bit_count == 4'h7) begin
                                state <= ST_TX_ACK;
                                bit_count <= 4'h0;
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        // master ack or nack on this rising edge ends the byte
                        if (scl_rise) begin
                            ev_tx_done <= 1'b1;
                            state <= sda ? ST_IDLE : ST_ACK;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // receive registers loaded from the shifter on completion
    always_ff @(posedge CLK) begin
        if (ev_rx_one) begin
            first_rx_byte <= shift;
        end
        if (ev_rx_two) begin
            second_rx_byte <= shift;
        end
    end

    // transmit byte written by software; receive byte two untouched
    always_ff @(posedge CLK) begin
        if (SRST) begin
            tx_byte <= 8'h00;
        end else if (WR && ADDR == ADDR_RX_TWO_TX_BYTE) begin
            tx_byte <= WDATA;
        end
    end

    // address and enable register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            slave_address_reg <= RST_SLAVE_ADDRESS;
        end else if (WR && ADDR == ADDR_SLAVE_ADDRESS) begin
            slave_address_reg <= WDATA;
        end
    end

    // interrupt enables in control bits 7..4
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_enable <= RST_CONTROL_STATUS[7:4];
        end else if (ctrl_wr) begin
            irq_enable <= WDATA[7:4];
        end
    end

    // done flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            done_flags <= RST_CONTROL_STATUS[2:0];
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ctrl_wr && !WDATA[i]) begin
                    done_flags[i] <= 1'b0;
                end
            end
            if (ev_tx_done) begin
                done_flags[BIT_TX_DONE_FLAG] <= 1'b1;
            end
            if (ev_rx_two) begin
                done_flags[BIT_RX_TWO_DONE_FLAG] <= 1'b1;
            end
            if (ev_rx_one) begin
                done_flags[BIT_RX_ONE_DONE_FLAG] <= 1'b1;
            end
        end
    end

    // event mask register gates flags onto the interrupt line
    always_ff @(posedge CLK) begin
        if (SRST) begin
            event_mask <= RST_EVENT_MASK;
        end else if (WR && ADDR == ADDR_FLAG_MASK) begin
            event_mask <= WDATA[2:0];
        end
    end

    // master engine event held sticky; write one to clear, event wins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            master_flag <= 1'b0;
        end else if (MASTER_IRQ_EVENT) begin
            master_flag <= 1'b1;
        end else if (WR && ADDR == ADDR_FLAG_STATUS && WDATA[3]) begin
            master_flag <= 1'b0;
        end
    end

    // interrupt outputs; mask bit set means the flag may interrupt
    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
            MASTER_IRQ <= 1'b0;
        end else begin
            IRQ <= |(done_flags & irq_enable[2:0] & event_mask);
            MASTER_IRQ <= master_flag & irq_enable[3];
        end
    end

    assign control_read = {irq_enable, 1'b0, done_flags};

    // register read, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                ADDR_SLAVE_ADDRESS: RDATA <= slave_address_reg;
                ADDR_CONTROL_STATUS: RDATA <= control_read;
                ADDR_RX_BYTE_ONE: RDATA <= first_rx_byte;
                ADDR_RX_TWO_TX_BYTE: RDATA <= second_rx_byte;
                ADDR_FLAG_STATUS: RDATA <= {4'h0, master_flag, done_flags};
                ADDR_FLAG_MASK: RDATA <= {5'h00, event_mask};
                default: RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // sda driver: ack low, or transmit bit low; hold time after scl fall
    always_ff @(posedge CLK) begin
        if (SRST) begin
            hold_count <= 8'h00;
            sda_level <= 1'b1;
        end else if (scl_fall) begin
            hold_count <= 8'(HOLD_CYCLES);
        end else if (hold_count != 8'h00) begin
            hold_count <= hold_count - 8'h01;
        end else begin
            sda_level <= ~(ack_drive || (state == ST_TX && !shift[7]));
        end
    end

    assign sda_drive = ~sda_level;
    assign SDA_OUT = 1'b0;
    assign SDA_OE = sda_drive;
endmodule : slave_i2c_port

// File: inc/slave_i2c_pkg.sv
// slave i2c port package: register offsets, field positions, reset values
// assumes an 8-bit special function register space addressed by byte offset
package slave_i2c_pkg;
    // register offsets
    localparam logic [7:0] ADDR_SLAVE_ADDRESS = 8'hE9;
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'hEA;
    localparam logic [7:0] ADDR_RX_BYTE_ONE = 8'hEB;
    localparam logic [7:0] ADDR_RX_TWO_TX_BYTE = 8'hEC;
    localparam logic [7:0] ADDR_FLAG_STATUS = 8'hED;
    localparam logic [7:0] ADDR_FLAG_MASK = 8'hEE;
    // control/status field positions
    localparam int BIT_MASTER_IRQ_ENABLE = 7;
    localparam int BIT_TX_DONE_IRQ_ENABLE = 6;
    localparam int BIT_RX_TWO_IRQ_ENABLE = 5;
    localparam int BIT_RX_ONE_IRQ_ENABLE = 4;
    localparam int BIT_TX_DONE_FLAG = 2;
    localparam int BIT_RX_TWO_DONE_FLAG = 1;
    localparam int BIT_RX_ONE_DONE_FLAG = 0;
    localparam int BIT_SLAVE_PORT_ENABLE = 0;
    // reset values
    localparam logic [7:0] RST_SLAVE_ADDRESS = 8'h64;
    localparam logic [7:0] RST_CONTROL_STATUS = 8'h04;
    localparam logic [2:0] RST_EVENT_MASK = 3'h0;
    // bus timing: 100 mhz system clock; the two-stage synchroniser alone
    // delays sda past the scl fall, so an 80 ns link clock still fits
    localparam int CLK_PERIOD_NS = 10;
    localparam int HOLD_TIME_NS = 0;
    localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // link engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_TX = 3'b100,
        ST_TX_ACK = 3'b101
    } link_state_type;
endpackage : slave_i2c_pkg

// File: tb/slave_i2c_port_assertions.sv
// checker for the slave i2c port, bound to its top module
// assumes the bench drives SCL with a low phase of at least four system clocks
`timescale 1ns/1ps
module slave_i2c_port_assertions (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register port
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // interrupts
    input wire logic MASTER_IRQ_EVENT,
    input wire logic IRQ,
    input wire logic MASTER_IRQ,
    // i2c pins
    input wire logic SCL_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    // read data stands only in the slot after a read strobe
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside its slot");
    // interrupts come out of reset quiet, though the tx flag resets set
    a_irq_reset: assert property ($fell(SRST) |-> !IRQ && !MASTER_IRQ)
        else $error("interrupt high after reset");
    // sticky flags and enables drop only by register writes
    a_irq_fall: assert property ($fell(IRQ) |-> $past(WR) || $past(WR, 2))
        else $error("irq dropped without a write");
    a_mirq_fall: assert property ($fell(MASTER_IRQ) |-> $past(WR) || $past(WR, 2))
        else $error("master irq dropped without a write");
    // with no write and no bus edge for a while, irq must hold; with no write and no master event, master irq must hold
    a_irq_quiet: assert property ((!WR && $stable(SCL_IN)) [*8] |-> $stable(IRQ))
        else $error("irq moved without a cause");
    a_mirq_quiet: assert property ((!WR && !MASTER_IRQ_EVENT) [*4] |-> $stable(MASTER_IRQ))
        else $error("master irq moved without a cause");
    // open drain: the data output never drives high
    a_sda_low: assert property (SDA_OE |-> SDA_OUT == 1'b0)
        else $error("sda driven high");
    // the slave launches a new SDA level only at an edge where SCL is low
    a_sda_scl: assert property ($changed(SDA_OE) |-> !$past(SCL_IN))
        else $error("sda moved while scl high");
    // data hold after the falling clock edge, given by the synchroniser delay
    a_sda_hold: assert property ($fell(SCL_IN) |=> $stable(SDA_OE) [*3])
        else $error("sda hold too short");
endmodule : slave_i2c_port_assertions

bind slave_i2c_port slave_i2c_port_assertions slave_i2c_port_assertions_i (.CLK, .SRST, .WR, .RD, .RDATA,
    .MASTER_IRQ_EVENT, .IRQ, .MASTER_IRQ, .SCL_IN, .SDA_OUT, .SDA_OE);

// File: tb/i2c_master_model.sv
// behavioural i2c bus master driving SCL and pulling SDA low
// assumes the bench resolves SDA with a pull-up
`timescale 1ns/1ps
module i2c_master_model #(
    parameter int HI_NS = 40,
    parameter int LO_NS = 40
) (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // idle bus: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // start: data falls while the clock is high
    task automatic start();
        sda_low = 1'b1;
        #(HI_NS) scl = 1'b0;
    endtask : start
    // nine clocks of 80 ns; a set bit releases the line, data moves mid low phase
    task automatic bits(input logic [8:0] v, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            #(LO_NS / 2) sda_low = !v[i];
            #(LO_NS / 2) scl = 1'b1;
            #(HI_NS / 2) r[i] = sda;
            #(HI_NS / 2) scl = 1'b0;
        end
    endtask : bits
    // stop: data rises while the clock is high
    task automatic stop();
        #(LO_NS / 2) sda_low = 1'b1;
        #(LO_NS / 2) scl = 1'b1;
        #(HI_NS) sda_low = 1'b0;
        #(LO_NS);
    endtask : stop
endmodule : i2c_master_model

// File: tb/tb.sv
// self-checking bench for the slave i2c port
// assumes the partner master model and the bound checker
`timescale 1ns/1ps
module tb;
    import slave_i2c_pkg::*;
    logic CLK, SRST, WR, RD, MASTER_IRQ_EVENT, IRQ, MASTER_IRQ, SDA_OUT, SDA_OE, scl, sda_low, ack;
    logic [7:0] ADDR, WDATA, RDATA, v, b1, b2, t, d;
    logic [8:0] r;
    integer seed = 22, mismatches = 0, n_tests = 0, cyc = 0;
    // pull-up bus: low while any party enables its driver
    wire logic sda = !(sda_low || SDA_OE);
    slave_i2c_port slave_i2c_port_i (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .MASTER_IRQ_EVENT,
        .IRQ, .MASTER_IRQ, .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT, .SDA_OE);
    i2c_master_model i2c_master_model_i (.scl, .sda_low, .sda);
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic chk(input string n, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // control register as software should read it: enables 7..4, flags 2..0
    function automatic logic [7:0] ctrl_exp(input logic [7:0] en, input logic [2:0] fl);
        return (en & 8'hF0) | {5'h00, fl};
    endfunction : ctrl_exp
    task automatic wr(input logic [7:0] a, dt);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= dt;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    // read data is taken in the single cycle after the strobe
    task automatic rc(input string n, input logic [7:0] a, e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(n, RDATA, e);
    endtask : rc
    // write then give the registered interrupts time to settle
    task automatic pins(input logic [7:0] a, dt, input logic ei, em);
        wr(a, dt);
        repeat (4) @(posedge CLK);
        #1;
        chk("irq", {7'h00, IRQ}, {7'h00, ei});
        chk("mirq", {7'h00, MASTER_IRQ}, {7'h00, em});
    endtask : pins
    // frames start on a falling system clock so pins never move on a sampling edge
    task automatic i2c_wr(input logic [7:0] a, d1, d2);
        @(negedge CLK);
        i2c_master_model_i.start();
        i2c_master_model_i.bits({a, 1'b1}, r);
        ack = !r[0];
        i2c_master_model_i.bits({d1, 1'b1}, r);
        i2c_master_model_i.bits({d2, 1'b1}, r);
        i2c_master_model_i.stop();
    endtask : i2c_wr
    // master nacks the only byte it reads
    task automatic i2c_rd(input logic [7:0] a);
        @(negedge CLK);
        i2c_master_model_i.start();
        i2c_master_model_i.bits({a, 1'b1}, r);
        ack = !r[0];
        i2c_master_model_i.bits(9'h1FF, r);
        d = r[8:1];
        i2c_master_model_i.stop();
    endtask : i2c_rd
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // hang guard, well above the length of the sequence
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        {SRST, WR, RD, MASTER_IRQ_EVENT, ADDR, WDATA} = {1'b1, 19'h0};
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        rc("ctrl", ADDR_CONTROL_STATUS, RST_CONTROL_STATUS);
        rc("sadr", ADDR_SLAVE_ADDRESS, RST_SLAVE_ADDRESS);
        rc("gap", 8'h10, 8'h00);
        // enables hold what is written; writing one keeps the flags
        repeat (4) begin
            v = $random(seed);
            wr(ADDR_CONTROL_STATUS, v | 8'h07);
            rc("en", ADDR_CONTROL_STATUS, ctrl_exp(v, 3'h4));
        end
        wr(ADDR_CONTROL_STATUS, 8'h00);
        rc("clr", ADDR_CONTROL_STATUS, ctrl_exp(8'h00, 3'h0));
        i2c_wr(RST_SLAVE_ADDRESS, 8'h5A, 8'hA5);
        chk("off", {7'h00, ack}, 8'h00);
        v = {2'b01, 5'($random(seed)), 1'b1};
        wr(ADDR_SLAVE_ADDRESS, v);
        rc("sadr", ADDR_SLAVE_ADDRESS, v);
        b1 = $random(seed);
        b2 = $random(seed);
        i2c_wr((v & 8'hFE) ^ 8'h02, b1, b2);
        chk("miss", {7'h00, ack}, 8'h00);
        i2c_wr(v & 8'hFE, b1, b2);
        chk("hit", {7'h00, ack}, 8'h01);
        rc("rx1", ADDR_RX_BYTE_ONE, b1);
        rc("rx2", ADDR_RX_TWO_TX_BYTE, b2);
        rc("flg", ADDR_CONTROL_STATUS, ctrl_exp(8'h00, 3'h3));
        wr(ADDR_FLAG_MASK, 8'h07);
        rc("msk", ADDR_FLAG_MASK, 8'h07);
        pins(ADDR_CONTROL_STATUS, 8'h13, 1'b1, 1'b0);
        pins(ADDR_CONTROL_STATUS, 8'h03, 1'b0, 1'b0);
        pins(ADDR_CONTROL_STATUS, 8'h23, 1'b1, 1'b0);
        pins(ADDR_CONTROL_STATUS, 8'h21, 1'b0, 1'b0);
        pins(ADDR_CONTROL_STATUS, 8'h00, 1'b0, 1'b0);
        t = $random(seed);
        wr(ADDR_RX_TWO_TX_BYTE, t);
        rc("keep", ADDR_RX_TWO_TX_BYTE, b2);
        i2c_rd(v);
        chk("txd", d, t);
        rc("txf", ADDR_CONTROL_STATUS, ctrl_exp(8'h00, 3'h4));
        pins(ADDR_CONTROL_STATUS, 8'h44, 1'b1, 1'b0);
        pins(ADDR_CONTROL_STATUS, 8'h40, 1'b0, 1'b0);
        @(posedge CLK);
        MASTER_IRQ_EVENT <= 1'b1;
        @(posedge CLK);
        MASTER_IRQ_EVENT <= 1'b0;
        rc("mfl", ADDR_FLAG_STATUS, 8'h08);
        pins(ADDR_CONTROL_STATUS, 8'h00, 1'b0, 1'b0);
        pins(ADDR_CONTROL_STATUS, 8'h80, 1'b0, 1'b1);
        pins(ADDR_FLAG_STATUS, 8'h08, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule : tb
